// *** itc_edge_sync.sv ***
// Two-stage synchroniser with rising and falling edge pulses.
`timescale 1ns/1ps
module itc_edge_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Raw level and its edges
    input wire logic din,
    output logic rise,
    output logic fall
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            // Taking the pin level during reset keeps an idle-high pin from a false edge.
            meta_q <= din;
            sync_q <= din;
            prev_q <= din;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;
endmodule

// *** itc_host_model.sv ***
// Bus master standing in for the host processor on the timer's register bus.
`timescale 1ns/1ps
module itc_host_model
    import itc_pkg::*;
(
    // Clock
    input wire logic clk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [itc_pkg::ITC_ADDR_W-1:0] paddr,
    output logic [itc_pkg::ITC_DATA_W-1:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [itc_pkg::ITC_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
    end
    // Called just after a rising edge; ends one edge after release so calls never collide.
    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
                        output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= 4'h1;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // A released bus shows the inverse of its last address and data; pwrite keeps its last value and pstrb drops to zero.
        paddr <= ~a;
        pwdata <= {24'hFFFFFF, ~d};
        pstrb <= 4'h0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        xfer(a, 1'b1, d, r, e);
    endtask
    // Paired byte accesses, low byte first.
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        logic [31:0] r;
        logic e;
        xfer(a, 1'b0, 8'h00, r, e);
        v[7:0] = r[7:0];
        xfer(a, 1'b0, 8'h00, r, e);
        v[15:8] = r[7:0];
    endtask
    // Control byte always precedes the count it qualifies.
    task automatic prog_count(input int ch, input logic [7:0] ctl, input logic [15:0] n);
        wr(ITC_ADDR_CTRL, ctl);
        wr(8'(ITC_ADDR_CNT0 + 4 * ch), n[7:0]);
        wr(8'(ITC_ADDR_CNT0 + 4 * ch), n[15:8]);
    endtask
endmodule

// *** itc_pkg.sv ***
// Constants shared by the interval timer/counter block.
package itc_pkg;
    localparam int ITC_ADDR_W = 8;
    localparam int ITC_DATA_W = 32;
    localparam int ITC_CNT_W = 16;
    localparam int ITC_NUM_CH = 3;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] ITC_IDX_CNT0 = 8'h18;
    localparam logic [7:0] ITC_IDX_CNT1 = 8'h19;
    localparam logic [7:0] ITC_IDX_CNT2 = 8'h1A;
    localparam logic [7:0] ITC_IDX_CTRL = 8'h1B;
    localparam logic [7:0] ITC_ADDR_CNT0 = 8'(ITC_IDX_CNT0 * 4);
    localparam logic [7:0] ITC_ADDR_CNT1 = 8'(ITC_IDX_CNT1 * 4);
    localparam logic [7:0] ITC_ADDR_CNT2 = 8'(ITC_IDX_CNT2 * 4);
    localparam logic [7:0] ITC_ADDR_CTRL = 8'(ITC_IDX_CTRL * 4);
    // Control byte fields.
    localparam int ITC_SEL_HI = 7;
    localparam int ITC_SEL_LO = 6;
    localparam int ITC_ACC_HI = 5;
    localparam int ITC_ACC_LO = 4;
    localparam int ITC_MODE_HI = 3;
    localparam int ITC_MODE_LO = 1;
    localparam int ITC_BCD_BIT = 0;
    localparam int ITC_RB_CNT_N = 5;
    localparam int ITC_RB_STA_N = 4;
    localparam int ITC_RB_SEL0 = 1;
    localparam logic [1:0] ITC_SEL_READBACK = 2'h3;
    // Access types.
    localparam logic [1:0] ITC_ACC_LATCH = 2'h0;
    localparam logic [1:0] ITC_ACC_LSB = 2'h1;
    localparam logic [1:0] ITC_ACC_MSB = 2'h2;
    localparam logic [1:0] ITC_ACC_LH = 2'h3;
    // Operating modes; mode 3 ignores the top mode bit.
    localparam logic [1:0] ITC_MODE3_LOW = 2'h3;
    localparam logic [2:0] ITC_MODE4 = 3'h4;
    localparam logic [2:0] ITC_MODE5 = 3'h5;
    // Reset values.
    localparam logic [2:0] ITC_MODE_RST = 3'h0;
    localparam logic [1:0] ITC_ACC_RST = 2'h1;
    localparam logic [15:0] ITC_CNT_RST = 16'h0000;
    // Decrement steps.
    localparam logic [1:0] ITC_STEP_ONE = 2'h1;
    localparam logic [1:0] ITC_STEP_TWO = 2'h2;
    localparam logic [1:0] ITC_STEP_THREE = 2'h3;
endpackage

// *** itc_timer.sv ***
// Three-channel interval timer/counter with an APB register slave.
//
// Behaviour
// - Mode 3 even count: step two, half high
// - Mode 3 terminal: toggle output, reload, repeat
// - Mode 3 odd: high first minus one, low three
// - Mode 3 odd: high (N+1)/2, low (N-1)/2
// - Mode 4 set: output high, count after load
// - Mode 4 terminal: output low one clock
// - Mode 4 rewrite: new count on next clock
// - Mode 4: gate low holds the count
// - Mode 5: gate rise starts, retriggers, strobes
// - Control byte routed by select field, any order
// - Read-back exposes count, mode, output, null flag
// - Read-back count latch for all selected counters
// - Read-back status latch; next read returns it
// - Latch command copies count to hold register
// - Next read after latch returns held value
// - Control write-only at 27; counters 24 to 26
// - Control byte: select, access, mode, decimal
// - Read-back bits: count, status, counter selects
// - Status: output, null, access, mode, decimal
// - Three 16-bit counters, own clock, gate, output
`timescale 1ns/1ps
module itc_timer
    import itc_pkg::*;
#(
    parameter int NUM_CH = itc_pkg::ITC_NUM_CH,
    parameter int CNT_W = itc_pkg::ITC_CNT_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [itc_pkg::ITC_ADDR_W-1:0] paddr,
    input wire logic [itc_pkg::ITC_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [itc_pkg::ITC_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Counter pins
    input wire logic [2:0] cnt_clk,
    input wire logic [2:0] cnt_gate,
    output logic [2:0] cnt_out
);
    import itc_pkg::*;

    if (NUM_CH != ITC_NUM_CH || CNT_W != ITC_CNT_W) begin : g_check
        $error("itc_timer serves three 16-bit counters only");
    end

    logic pready_q;
    logic pslverr_q;
    logic [ITC_DATA_W-1:0] prdata_q;
    logic [2:0] out_q;
    logic [7:0] rd_byte [3];
    logic [2:0] hit_ch;
    logic hit_ctrl;
    logic done;
    logic wr_done;
    logic rd_done;
    logic ctrl_wr;
    logic [7:0] wbyte;

    // Registers are one byte wide in the low lane of each word.
    assign wbyte = pwdata[7:0];
    assign hit_ch[0] = (paddr == ITC_ADDR_CNT0);
    assign hit_ch[1] = (paddr == ITC_ADDR_CNT1);
    assign hit_ch[2] = (paddr == ITC_ADDR_CNT2);
    assign hit_ctrl = (paddr == ITC_ADDR_CTRL);
    assign done = psel & penable & pready_q;
    assign wr_done = done & pwrite & pstrb[0];
    assign rd_done = done & ~pwrite;
    assign ctrl_wr = wr_done & hit_ctrl;

    // Answer in the first access cycle; side effects happen at the edge that ends it.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= psel & ~penable;
            pslverr_q <= psel & ~penable & ~(|hit_ch | hit_ctrl);
            prdata_q <= '0;
            if (psel && !penable && !pwrite) begin
                for (int k = 0; k < 3; k++) begin
                    if (hit_ch[k]) begin
                        prdata_q <= {24'h000000, rd_byte[k]};
                    end
                end
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign cnt_out = out_q;

    // Decrement by one, in binary or in four decimal digits.
    function automatic logic [15:0] dec1(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        logic borrow;
        r = v;
        borrow = 1'b1;
        if (!bcd) begin
            r = v - 16'h0001;
        end else begin
            for (int d = 0; d < 4; d++) begin
                if (borrow) begin
                    if (r[d*4 +: 4] == 4'h0) begin
                        r[d*4 +: 4] = 4'h9;
                    end else begin
                        r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
                        borrow = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] dec_n(input logic [15:0] v, input logic [1:0] n,
                                          input logic bcd);
        logic [15:0] r;
        r = v;
        for (int s = 0; s < 3; s++) begin
            if (2'(s) < n) begin
                r = dec1(r, bcd);
            end
        end
        return r;
    endfunction

    for (genvar i = 0; i < 3; i++) begin : g_ch
        logic clk_fall;
        logic gate_rise;
        logic [2:0] mode_q;
        logic [1:0] acc_q;
        logic bcd_q;
        logic [15:0] cr_q;
        logic wr_ptr_q;
        logic wr_full;
        logic [15:0] ce_q;
        logic [15:0] ce_next;
        logic [1:0] step;
        logic null_q;
        logic pend_q;
        logic armed_q;
        logic trig_q;
        logic [15:0] hold_q;
        logic held_q;
        logic [7:0] stat_q;
        logic stat_held_q;
        logic rd_ptr_q;
        logic [15:0] src;
        logic cw_sel;
        logic rb_sel;
        logic rd_hit;
        logic is_m3;

        itc_edge_sync u_clk_sync (
            .clk(clk),
            .resetn(resetn),
            .din(cnt_clk[i]),
            .rise(),
            .fall(clk_fall)
        );

        itc_edge_sync u_gate_sync (
            .clk(clk),
            .resetn(resetn),
            .din(cnt_gate[i]),
            .rise(gate_rise),
            .fall()
        );

        // Control byte routed by its select field; read-back uses its own select bits.
        assign cw_sel = ctrl_wr && wbyte[ITC_SEL_HI:ITC_SEL_LO] == 2'(i);
        assign rb_sel = ctrl_wr && wbyte[ITC_SEL_HI:ITC_SEL_LO] == ITC_SEL_READBACK
                        && wbyte[ITC_RB_SEL0 + i];
        assign rd_hit = rd_done & hit_ch[i];
        assign is_m3 = (mode_q[1:0] == ITC_MODE3_LOW);

        // Mode, access and decimal fields from a control byte that is not a latch.
        always_ff @(posedge clk) begin
            if (!resetn) begin
                mode_q <= ITC_MODE_RST;
                acc_q <= ITC_ACC_RST;
                bcd_q <= 1'b0;
            end else if (cw_sel && wbyte[ITC_ACC_HI:ITC_ACC_LO] != ITC_ACC_LATCH) begin
                mode_q <= wbyte[ITC_MODE_HI:ITC_MODE_LO];
                acc_q <= wbyte[ITC_ACC_HI:ITC_ACC_LO];
                bcd_q <= wbyte[ITC_BCD_BIT];
            end
        end

        // Count register written byte by byte.
        assign wr_full = wr_done && hit_ch[i] && (acc_q != ITC_ACC_LH || wr_ptr_q);
        always_ff @(posedge clk) begin
            if (!resetn) begin
                cr_q <= ITC_CNT_RST;
                wr_ptr_q <= 1'b0;
            end else if (cw_sel && wbyte[ITC_ACC_HI:ITC_ACC_LO] != ITC_ACC_LATCH) begin
                wr_ptr_q <= 1'b0;
            end else if (wr_done && hit_ch[i]) begin
                case (acc_q)
                    ITC_ACC_LSB: cr_q <= {8'h00, wbyte};
                    ITC_ACC_MSB: cr_q <= {wbyte, 8'h00};
                    ITC_ACC_LH: begin
                        if (wr_ptr_q) begin
                            cr_q[15:8] <= wbyte;
                        end else begin
                            cr_q[7:0] <= wbyte;
                        end
                        wr_ptr_q <= ~wr_ptr_q;
                    end
                    default: cr_q <= cr_q;
                endcase
            end
        end

        // Odd counts take one off in the high phase and three in the low phase.
        always_comb begin
            if (!is_m3) begin
                step = ITC_STEP_ONE;
            end else if (ce_q[0]) begin
                step = out_q[i] ? ITC_STEP_ONE : ITC_STEP_THREE;
            end else begin
                step = ITC_STEP_TWO;
            end
            ce_next = dec_n(ce_q, step, bcd_q);
        end

        // Counting engine, advanced on each falling edge of the counter clock.
        always_ff @(posedge clk) begin
            if (!resetn) begin
                ce_q <= ITC_CNT_RST;
                out_q[i] <= 1'b1;
                null_q <= 1'b0;
                pend_q <= 1'b0;
                armed_q <= 1'b0;
                trig_q <= 1'b0;
            end else if (cw_sel && wbyte[ITC_ACC_HI:ITC_ACC_LO] != ITC_ACC_LATCH) begin
                out_q[i] <= 1'b1;
                null_q <= 1'b1;
                pend_q <= 1'b0;
                armed_q <= 1'b0;
                trig_q <= 1'b0;
            end else begin
                if (gate_rise) begin
                    trig_q <= 1'b1;
                end
                if (clk_fall) begin
                    if (mode_q == ITC_MODE5) begin
                        if (trig_q || gate_rise) begin
                            ce_q <= cr_q;
                            null_q <= 1'b0;
                            armed_q <= 1'b1;
                            trig_q <= 1'b0;
                        end else if (armed_q) begin
                            ce_q <= ce_next;
                            if (ce_next == ITC_CNT_RST) begin
                                out_q[i] <= 1'b0;
                                armed_q <= 1'b0;
                            end
                        end
                        if (!out_q[i]) begin
                            out_q[i] <= 1'b1;
                        end
                    end else if (mode_q == ITC_MODE4) begin
                        if (pend_q) begin
                            ce_q <= cr_q;
                            null_q <= 1'b0;
                            pend_q <= 1'b0;
                            armed_q <= 1'b1;
                        end else if (armed_q && cnt_gate[i]) begin
                            ce_q <= ce_next;
                            if (ce_next == ITC_CNT_RST) begin
                                out_q[i] <= 1'b0;
                                armed_q <= 1'b0;
                            end
                        end
                        if (!out_q[i]) begin
                            out_q[i] <= 1'b1;
                        end
                    end else if (is_m3) begin
                        if (!cnt_gate[i]) begin
                            out_q[i] <= 1'b1;
                        end else if ((pend_q && !armed_q) || trig_q) begin
                            ce_q <= cr_q;
                            null_q <= 1'b0;
                            pend_q <= 1'b0;
                            armed_q <= 1'b1;
                            trig_q <= 1'b0;
                        end else if (armed_q) begin
                            if (ce_next == ITC_CNT_RST) begin
                                out_q[i] <= ~out_q[i];
                                ce_q <= cr_q;
                                null_q <= 1'b0;
                                pend_q <= 1'b0;
                            end else begin
                                ce_q <= ce_next;
                            end
                        end
                    end
                end
                // A count written in the same cycle as a load is not lost.
                if (wr_full) begin
                    null_q <= 1'b1;
                    pend_q <= 1'b1;
                end
            end
        end

        // Latched count, latched status and the read byte pointer.
        always_ff @(posedge clk) begin
            if (!resetn) begin
                hold_q <= ITC_CNT_RST;
                held_q <= 1'b0;
                stat_q <= 8'h00;
                stat_held_q <= 1'b0;
                rd_ptr_q <= 1'b0;
            end else begin
                if (rd_hit) begin
                    if (stat_held_q) begin
                        stat_held_q <= 1'b0;
                    end else begin
                        if (acc_q == ITC_ACC_LH) begin
                            rd_ptr_q <= ~rd_ptr_q;
                        end
                        if (held_q && (acc_q != ITC_ACC_LH || rd_ptr_q)) begin
                            held_q <= 1'b0;
                        end
                    end
                end
                if (cw_sel && wbyte[ITC_ACC_HI:ITC_ACC_LO] != ITC_ACC_LATCH) begin
                    held_q <= 1'b0;
                    stat_held_q <= 1'b0;
                    rd_ptr_q <= 1'b0;
                end
                // A second latch before the read keeps the first value.
                if (!held_q && ((cw_sel && wbyte[ITC_ACC_HI:ITC_ACC_LO] == ITC_ACC_LATCH)
                        || (rb_sel && !wbyte[ITC_RB_CNT_N]))) begin
                    hold_q <= ce_q;
                    held_q <= 1'b1;
                end
                if (!stat_held_q && rb_sel && !wbyte[ITC_RB_STA_N]) begin
                    stat_q <= {out_q[i], null_q, acc_q, mode_q, bcd_q};
                    stat_held_q <= 1'b1;
                end
            end
        end

        assign src = held_q ? hold_q : ce_q;
        always_comb begin
            if (stat_held_q) begin
                rd_byte[i] = stat_q;
            end else if (acc_q == ITC_ACC_MSB || (acc_q == ITC_ACC_LH && rd_ptr_q)) begin
                rd_byte[i] = src[15:8];
            end else begin
                rd_byte[i] = src[7:0];
            end
        end
    end
endmodule

// *** itc_timer_properties.sv ***
// Concurrent checks on the timer's register bus and counter outputs.
`timescale 1ns/1ps
module itc_timer_properties
    import itc_pkg::*;
#(
    parameter int NUM_CH = 3,
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [itc_pkg::ITC_ADDR_W-1:0] paddr,
    input wire logic [itc_pkg::ITC_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [itc_pkg::ITC_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Counter pins
    input wire logic [2:0] cnt_clk,
    input wire logic [2:0] cnt_gate,
    input wire logic [2:0] cnt_out
);
    logic mapped;
    assign mapped = paddr inside {ITC_ADDR_CNT0, ITC_ADDR_CNT1, ITC_ADDR_CNT2, ITC_ADDR_CTRL};
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_answer_next;
        psel && !penable |=> pready;
    endproperty
    a_answer_next: assert property (p_answer_next) else $error("no answer after setup");
    property p_ready_cause;
        pready |-> psel && penable && $past(psel && !penable);
    endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("answer without request");
    property p_err_unmapped;
        pready && !mapped |-> pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
    property p_ok_mapped;
        pready && mapped |-> !pslverr;
    endproperty
    a_ok_mapped: assert property (p_ok_mapped) else $error("mapped access refused");
    property p_ctrl_read_zero;
        pready && !pwrite && paddr == ITC_ADDR_CTRL |-> prdata == '0;
    endproperty
    a_ctrl_read_zero: assert property (p_ctrl_read_zero) else $error("control read");
    property p_byte_lane;
        pready |-> prdata[31:8] == '0;
    endproperty
    a_byte_lane: assert property (p_byte_lane) else $error("upper read bits set");
    property p_idle_quiet;
        !pready |-> prdata == '0 && !pslverr;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("bus answer while idle");
    property p_out_reset;
        $rose(resetn) |-> cnt_out == 3'b111;
    endproperty
    a_out_reset: assert property (p_out_reset) else $error("outputs low after reset");
    // A tick passes the synchroniser and the engine, so its clock fall shows four samples back.
    property p_fall_on_tick;
        $fell(cnt_out[0]) |-> $past(cnt_clk[0], 4) && !$past(cnt_clk[0], 3);
    endproperty
    a_fall_on_tick: assert property (p_fall_on_tick) else $error("output fell off tick");
endmodule
bind itc_timer itc_timer_properties #(.NUM_CH(NUM_CH), .CNT_W(CNT_W)) i_props (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cnt_clk(cnt_clk), .cnt_gate(cnt_gate), .cnt_out(cnt_out));

// *** testbench.sv ***
// Self-checking bench for the three-channel interval timer.
`timescale 1ns/1ps
module testbench;
    import itc_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] cnt_clk = 3'b111;
    logic [2:0] cnt_gate = 3'b111;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] pstrb;
    logic [2:0] cnt_out;
    logic [15:0] v;
    logic e;
    int n_mismatch = 0;
    int check_count = 0;
    int seed = 3;
    int div = 0;
    int n, t, lo, hi;
    always #5 clk = ~clk;
    // Counter clocks run at a tenth of the bus clock, inside the synchroniser's limit.
    always @(posedge clk) begin
        div <= (div == 4) ? 0 : div + 1;
        if (div == 4) cnt_clk <= ~cnt_clk;
    end
    itc_host_model i_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    itc_timer i_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cnt_clk(cnt_clk), .cnt_gate(cnt_gate),
        .cnt_out(cnt_out));
    function automatic logic [7:0] ctl(input logic [1:0] s, input logic [1:0] a,
                                       input logic [2:0] m);
        return {s, a, m, 1'b0};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic lvl(input int ch, input logic want, output int cyc);
        cyc = 0;
        while (cnt_out[ch] !== want && cyc < 5000) begin
            @(posedge clk);
            cyc++;
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        final_report();
    end
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        i_host.xfer(8'h70, 1'b0, 8'h00, r, e);
        check("unmapped error", {31'h0, e}, 32'h1);
        check("unmapped data", r, 32'h0);
        i_host.xfer(ITC_ADDR_CTRL, 1'b0, 8'h00, r, e);
        check("control read", {r[30:0], e}, 32'h0);
        $display("test decode done");
        for (int k = 0; k < 3; k++) begin
            n = (k == 0) ? 4 : (k == 1) ? 5 : 3 + ($random(seed) & 15);
            i_host.prog_count(0, ctl(2'h0, ITC_ACC_LH, (k == 1) ? 3'h7 : 3'h3), 16'(n));
            lvl(0, 1'b0, t);
            lvl(0, 1'b1, lo);
            lvl(0, 1'b0, hi);
            check("square low span", 32'(lo), 32'(n / 2 * 10));
            check("square high span", 32'(hi), 32'((n + 1) / 2 * 10));
        end
        // Decimal count of ten through a low-byte-only access: five ticks per phase.
        i_host.wr(ITC_ADDR_CTRL, ctl(2'h0, ITC_ACC_LSB, 3'h3) | 8'h01);
        i_host.wr(ITC_ADDR_CNT0, 8'h10);
        lvl(0, 1'b0, t);
        lvl(0, 1'b1, lo);
        lvl(0, 1'b0, hi);
        check("decimal low span", 32'(lo), 32'h32);
        check("decimal high span", 32'(hi), 32'h32);
        $display("test square wave done");
        n = 5 + ($random(seed) & 7);
        cnt_gate[1] <= 1'b0;
        i_host.prog_count(1, ctl(2'h1, ITC_ACC_LH, ITC_MODE4), 16'(n));
        check("strobe idle high", {31'h0, cnt_out[1]}, 32'h1);
        repeat (60) @(posedge clk);
        check("gated output", {31'h0, cnt_out[1]}, 32'h1);
        i_host.wr(ITC_ADDR_CTRL, 8'hE4);
        i_host.xfer(ITC_ADDR_CNT1, 1'b0, 8'h00, r, e);
        check("status byte", r, {24'h0, 2'b10, ITC_ACC_LH, ITC_MODE4, 1'b0});
        i_host.wr(ITC_ADDR_CTRL, ctl(2'h1, ITC_ACC_LATCH, 3'h0));
        i_host.rd16(ITC_ADDR_CNT1, v);
        check("latched count", {16'h0, v}, 32'(n));
        repeat (60) @(posedge clk);
        i_host.wr(ITC_ADDR_CTRL, 8'hD4);
        i_host.rd16(ITC_ADDR_CNT1, v);
        check("readback count", {16'h0, v}, 32'(n));
        cnt_gate[1] <= 1'b1;
        lvl(1, 1'b0, t);
        check("strobe delay", {31'h0, t >= (n - 1) * 10 && t <= (n + 2) * 10}, 32'h1);
        lvl(1, 1'b1, lo);
        check("strobe width", 32'(lo), 32'd10);
        // A count rewritten mid-run replaces the old one at the next tick.
        i_host.prog_count(1, ctl(2'h1, ITC_ACC_LH, ITC_MODE4), 16'h0028);
        repeat (60) @(posedge clk);
        n = 2 + ($random(seed) & 7);
        i_host.wr(ITC_ADDR_CNT1, 8'(n));
        i_host.wr(ITC_ADDR_CNT1, 8'h00);
        lvl(1, 1'b0, t);
        check("rewrite delay", {31'h0, t >= n * 10 && t <= (n + 1) * 10}, 32'h1);
        $display("test software strobe done");
        i_host.prog_count(2, ctl(2'h2, ITC_ACC_LH, ITC_MODE5), 16'd6);
        repeat (60) @(posedge clk);
        check("no trigger", {31'h0, cnt_out[2]}, 32'h1);
        for (int k = 0; k < 2; k++) begin
            cnt_gate[2] <= 1'b0;
            repeat (4) @(posedge clk);
            cnt_gate[2] <= 1'b1;
            repeat (30) @(posedge clk);
        end
        lvl(2, 1'b0, t);
        check("retrigger delay", {31'h0, t >= 20 && t <= 50}, 32'h1);
        lvl(2, 1'b1, lo);
        check("hardware strobe width", 32'(lo), 32'd10);
        $display("test hardware strobe done");
        final_report();
    end
endmodule
